// file: hw/wdcm_top.sv
/*
 * watchdog and clock monitor top: bus-rate divider, 18-bit watchdog
 * counter, stop and wait handling, reset generation and an AXI4-Lite
 * register slave.
 * assumes a 40 MHz clock, a CPU that pulses stop_enter_i, and a reset
 * pin and interrupt pin that arrive asynchronously.
 */
// The AXI4-Lite register port was decided locally.
`timescale 1ns/10ps

module wdcm_top #(
   parameter int unsigned WDOG_TIMEOUT = wdcm_pkg::WDOG_TIMEOUT_BUS
) (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_b_i,
   input  wire logic [15:0] s_axi_awaddr_i,
   input  wire logic        s_axi_awvalid_i,
   output logic             s_axi_awready_o,
   input  wire logic [31:0] s_axi_wdata_i,
   input  wire logic [3:0]  s_axi_wstrb_i,
   input  wire logic        s_axi_wvalid_i,
   output logic             s_axi_wready_o,
   output logic [1:0]       s_axi_bresp_o,
   output logic             s_axi_bvalid_o,
   input  wire logic        s_axi_bready_i,
   input  wire logic [15:0] s_axi_araddr_i,
   input  wire logic        s_axi_arvalid_i,
   output logic             s_axi_arready_o,
   output logic [31:0]      s_axi_rdata_o,
   output logic [1:0]       s_axi_rresp_o,
   output logic             s_axi_rvalid_o,
   input  wire logic        s_axi_rready_i,
   input  wire logic [7:0]  port_b_option_i,
   input  wire logic        stop_enter_i,
   input  wire logic        wait_mode_i,
   input  wire logic        irq_any_i,
   input  wire logic        clock_fault_i,
   input  wire logic        ext_irq_b_i,
   input  wire logic        reset_pin_i,
   output logic             reset_pin_o,
   output logic             reset_pin_oe_b_o,
   output logic             osc_run_o,
   output logic             bus_tick_o,
   output logic             sys_reset_o,
   output logic             irq_mask_clear_o,
   output logic             wait_exit_o
);
   import wdcm_pkg::*;

   function automatic wdcm_sel_type reg_sel(input logic [15:0] addr);
      if (addr[15:2] == ADDR_CONTROL[15:2]) begin
         return SEL_CONTROL;
      end else if (addr[15:2] == ADDR_OPTION[15:2]) begin
         return SEL_OPTION;
      end else if (addr[15:2] == ADDR_COUNT[15:2]) begin
         return SEL_COUNT;
      end else if (addr[15:2] == ADDR_SERVICE[15:2]) begin
         return SEL_SERVICE;
      end
      return SEL_NONE;
   endfunction

   // ==========================================================
   // pin synchronisers
   logic [1:0] irq_sync;
   logic [1:0] rpin_sync;

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         irq_sync  <= 2'h3;
         rpin_sync <= 2'h3;
      end else begin
         irq_sync  <= {irq_sync[0], ext_irq_b_i};
         rpin_sync <= {rpin_sync[0], reset_pin_i};
      end
   end

   // ==========================================================
   // registers and bus slave state
   logic                aw_held, w_held, next_aw_held, next_w_held;
   logic [15:0]         aw_addr, next_aw_addr;
   logic [31:0]         w_data, next_w_data;
   logic [3:0]          w_strb, next_w_strb;
   logic                bvalid, next_bvalid, rvalid, next_rvalid;
   logic [1:0]          bresp, next_bresp, rresp, next_rresp;
   logic [31:0]         rdata, next_rdata;
   logic [2:0]          option, next_option;
   logic                clock_monitor_enable, next_cme, cme_locked, next_cme_locked;
   logic                flag, next_flag;
   logic                wr_do, rd_do, service_hit, ctrl_read;
   wdcm_sel_type        wsel, rsel;

   // ==========================================================
   // power mode, watchdog and reset state
   wdcm_pmode_type      pmode, next_pmode;
   logic                by_reset, next_by_reset;
   logic [11:0]         stab, next_stab;
   logic [4:0]          div, next_div;
   logic                tick, next_tick;
   logic [WDOG_W-1:0]   wdog, next_wdog;
   logic [2:0]          hold, next_hold;
   logic                sys_rst, next_sys_rst;
   logic                drive_b, next_drive_b;
   logic                mask_clr, next_mask_clr;
   logic                wd_active, wd_fire, stop_take, stab_end;
   logic                cm_enable, cm_fire, cm_drive;

   assign wsel        = reg_sel(aw_addr);
   assign rsel        = reg_sel(s_axi_araddr_i);
   assign wr_do       = aw_held && w_held && !bvalid;
   assign rd_do       = s_axi_arvalid_i && !rvalid;
   assign service_hit = wr_do && wsel == SEL_SERVICE && w_strb[0] && !w_data[SERVICE_BIT];
   assign ctrl_read   = rd_do && rsel == SEL_CONTROL;

   always_comb begin
      next_aw_held    = aw_held;
      next_aw_addr    = aw_addr;
      next_w_held     = w_held;
      next_w_data     = w_data;
      next_w_strb     = w_strb;
      next_bvalid     = bvalid && !s_axi_bready_i;
      next_bresp      = bresp;
      next_rvalid     = rvalid && !s_axi_rready_i;
      next_rresp      = rresp;
      next_rdata      = rdata;
      next_option     = option;
      next_cme        = clock_monitor_enable;
      next_cme_locked = cme_locked;
      // address and data may arrive in either order
      if (s_axi_awvalid_i && s_axi_awready_o) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata_i;
         next_w_strb = s_axi_wstrb_i;
      end
      if (wr_do) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         if (wsel == SEL_OPTION && w_strb[0]) begin
            next_option = w_data[2:0];
         end
         if (wsel == SEL_CONTROL && w_strb[0] && !cme_locked) begin
            next_cme        = w_data[CTRL_CME_BIT];
            next_cme_locked = 1'b1;
         end
      end
      if (rd_do) begin
         next_rvalid = 1'b1;
         next_rresp  = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         next_rdata  = 32'h0000_0000;
         unique case (rsel)
            SEL_CONTROL: begin
               next_rdata[CTRL_FLAG_BIT] = flag;
               next_rdata[CTRL_CME_BIT]  = clock_monitor_enable;
            end
            SEL_OPTION:  next_rdata[2:0] = option;
            SEL_COUNT:   next_rdata[WDOG_W-1:0] = wdog;
            SEL_SERVICE: next_rdata[7:0] = port_b_option_i;
            SEL_NONE:    next_rdata = 32'h0000_0000;
         endcase
      end
      // a new event wins over the clearing read
      next_flag = wd_fire || cm_fire || (flag && !ctrl_read);
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         aw_held    <= 1'b0;
         aw_addr    <= 16'h0000;
         w_held     <= 1'b0;
         w_data     <= 32'h0000_0000;
         w_strb     <= 4'h0;
         bvalid     <= 1'b0;
         bresp      <= RESP_OKAY;
         rvalid     <= 1'b0;
         rresp      <= RESP_OKAY;
         rdata      <= 32'h0000_0000;
         option     <= OPTION_RST;
         clock_monitor_enable        <= 1'b0;
         cme_locked <= 1'b0;
         flag       <= 1'b0;
      end else begin
         aw_held    <= next_aw_held;
         aw_addr    <= next_aw_addr;
         w_held     <= next_w_held;
         w_data     <= next_w_data;
         w_strb     <= next_w_strb;
         bvalid     <= next_bvalid;
         bresp      <= next_bresp;
         rvalid     <= next_rvalid;
         rresp      <= next_rresp;
         rdata      <= next_rdata;
         option     <= next_option;
         clock_monitor_enable        <= next_cme;
         cme_locked <= next_cme_locked;
         flag       <= next_flag;
      end
   end

   assign s_axi_awready_o = !aw_held && !bvalid;
   assign s_axi_wready_o  = !w_held && !bvalid;
   assign s_axi_bvalid_o  = bvalid;
   assign s_axi_bresp_o   = bresp;
   assign s_axi_arready_o = !rvalid;
   assign s_axi_rvalid_o  = rvalid;
   assign s_axi_rresp_o   = rresp;
   assign s_axi_rdata_o   = rdata;

   // ==========================================================
   // clock monitor
   assign cm_enable = option[OPT_CFGB_BIT] ? option[OPT_STOP_DISABLE_EMULATION_BIT] : clock_monitor_enable;

   wdcm_clkmon u_clkmon (
      .clk_sys_i  (clk_sys_i),
      .rst_b_i    (rst_b_i),
      .enable_i   (cm_enable),
      .bus_tick_i (tick),
      .cm_fire_o  (cm_fire),
      .cm_drive_o (cm_drive)
   );

   // ==========================================================
   // power modes, bus divider, watchdog, reset generation
   assign wd_active = option[OPT_CFGB_BIT] && option[OPT_WDEN_BIT];
   assign wd_fire   = wd_active && tick && !sys_rst
                      && wdog == WDOG_W'(WDOG_TIMEOUT - 1);
   // stop is taken only from PM_RUN and refused while sys_rst is high, even with the stop-disable option set
   assign stop_take = pmode == PM_RUN && stop_enter_i && !sys_rst;
   assign stab_end  = pmode == PM_STABILISE && tick && stab == STAB_LAST;

   always_comb begin
      next_pmode    = pmode;
      next_by_reset = by_reset;
      next_stab     = stab;
      next_mask_clr = 1'b0;
      unique case (pmode)
         PM_RUN: begin
            if (stop_take) begin
               next_pmode    = PM_STOPPED;
               next_mask_clr = 1'b1;
            end
         end
         PM_STOPPED: begin
            // only a reset or the external interrupt restarts the oscillator
            if (sys_rst) begin
               next_pmode    = PM_STABILISE;
               next_by_reset = 1'b1;
               next_stab     = 12'h000;
            end else if (!irq_sync[1]) begin
               next_pmode    = PM_STABILISE;
               next_by_reset = 1'b0;
               next_stab     = 12'h000;
            end
         end
         PM_STABILISE: begin
            if (sys_rst) begin
               next_by_reset = 1'b1;
            end
            if (tick) begin
               next_stab = stab + 12'h001;
            end
            if (stab_end) begin
               next_pmode = PM_RUN;
            end
         end
         default: next_pmode = PM_RUN;
      endcase
      // oscillator halted: no ticks reach the watchdog
      // stop_take too, so no tick slips into the first stopped cycle
      if (pmode == PM_STOPPED || stop_take || clock_fault_i) begin
         next_div  = div;
         next_tick = 1'b0;
      end else begin
         next_div  = (div == BUS_DIV_LAST) ? 5'h00 : div + 5'h01;
         next_tick = (div == BUS_DIV_LAST);
      end
      // clears outrank counting; wait mode is not looked at
      if (sys_rst || service_hit || stop_take) begin
         next_wdog = '0;
      end else if (stab_end && by_reset) begin
         next_wdog = '0;
      end else if (wd_active && tick) begin
         next_wdog = wdog + WDOG_W'(1);
      end else begin
         next_wdog = wdog;
      end
      if (wd_fire) begin
         next_hold = RST_PULSE_BUS;
      end else if (hold != 3'h0 && tick) begin
         next_hold = hold - 3'h1;
      end else begin
         next_hold = hold;
      end
      next_sys_rst = wd_fire || cm_fire || next_hold != 3'h0 || cm_drive
                     || !rpin_sync[1];
      // the pin is input only in configuration B
      next_drive_b = !(!option[OPT_CFGB_BIT] && (next_hold != 3'h0 || cm_drive
                                                 || cm_fire));
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         pmode    <= PM_RUN;
         by_reset <= 1'b0;
         stab     <= 12'h000;
         div      <= 5'h00;
         tick     <= 1'b0;
         wdog     <= '0;
         hold     <= 3'h0;
         sys_rst  <= 1'b0;
         drive_b  <= 1'b1;
         mask_clr <= 1'b0;
      end else begin
         pmode    <= next_pmode;
         by_reset <= next_by_reset;
         stab     <= next_stab;
         div      <= next_div;
         tick     <= next_tick;
         wdog     <= next_wdog;
         hold     <= next_hold;
         sys_rst  <= next_sys_rst;
         drive_b  <= next_drive_b;
         mask_clr <= next_mask_clr;
      end
   end

   assign reset_pin_o      = 1'b0;
   assign reset_pin_oe_b_o = drive_b;
   assign osc_run_o        = (pmode != PM_STOPPED);
   assign bus_tick_o       = tick;
   assign sys_reset_o      = sys_rst;
   assign irq_mask_clear_o = mask_clr;
   assign wait_exit_o      = wait_mode_i && (irq_any_i || sys_rst);

endmodule

// file: hw/wdcm_pkg.sv
/*
 * shared constants and types of the watchdog and clock monitor block:
 * register offsets, field positions, reset values, timing counts, states.
 * assumes a 40 MHz system clock and a 2 MHz bus rate derived from it.
 */
package wdcm_pkg;

   // ==========================================================
   // clock and bus rate
   localparam int unsigned CLK_HZ          = 40_000_000;
   localparam int unsigned BUS_RATE_HZ     = 2_000_000;
   localparam int unsigned BUS_DIV         = CLK_HZ / BUS_RATE_HZ;
   localparam logic [4:0]  BUS_DIV_LAST    = 5'(BUS_DIV - 1);

   // ==========================================================
   // timing
   localparam int unsigned WDOG_W          = 18;
   localparam int unsigned WDOG_TIMEOUT_MS = 64;
   localparam int unsigned WDOG_TIMEOUT_BUS = WDOG_TIMEOUT_MS * (BUS_RATE_HZ / 1000);
   localparam int unsigned STAB_BUS        = 4064;
   localparam logic [11:0] STAB_LAST       = 12'(STAB_BUS - 1);
   localparam int unsigned CM_WINDOW_NS    = 20000;
   localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
   localparam logic [9:0]  CM_WINDOW_CYC   = 10'(CM_WINDOW_NS / CLK_PERIOD_NS);
   localparam logic [2:0]  CM_TAIL_BUS     = 3'h4;
   localparam logic [2:0]  RST_PULSE_BUS   = 3'h4;

   // ==========================================================
   // register map (byte addresses)
   localparam logic [15:0] ADDR_CONTROL    = 16'h0000;
   localparam logic [15:0] ADDR_OPTION     = 16'h0004;
   localparam logic [15:0] ADDR_COUNT      = 16'h0008;
   localparam logic [15:0] ADDR_SERVICE    = 16'h3ff0;

   // ==========================================================
   // fields and reset values
   localparam int unsigned CTRL_FLAG_BIT   = 7;
   localparam int unsigned CTRL_CME_BIT    = 4;
   localparam int unsigned OPT_CFGB_BIT    = 0;
   localparam int unsigned OPT_WDEN_BIT    = 1;
   localparam int unsigned OPT_STOP_DISABLE_EMULATION_BIT = 2;
   localparam int unsigned SERVICE_BIT     = 0;
   localparam logic [2:0]  OPTION_RST      = 3'h0;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   // ==========================================================
   // register select and states
   typedef enum logic [2:0] {
      SEL_NONE    = 3'h0,
      SEL_CONTROL = 3'h1,
      SEL_OPTION  = 3'h2,
      SEL_COUNT   = 3'h3,
      SEL_SERVICE = 3'h4
   } wdcm_sel_type;

   typedef enum logic [1:0] {
      PM_RUN       = 2'b00,
      PM_STOPPED   = 2'b01,
      PM_STABILISE = 2'b11
   } wdcm_pmode_type;

   typedef enum logic [1:0] {
      CM_IDLE   = 2'b00,
      CM_ABSENT = 2'b01,
      CM_TAIL   = 2'b11
   } wdcm_cm_type;

endpackage

// file: hw/wdcm_clkmon.sv
/*
 * clock monitor: watches the bus tick stream and flags a missing or slow
 * bus clock, then asks for the reset pin to be driven.
 * assumes bus_tick_i is a one-cycle pulse on clk_sys_i from the divider.
 */
`timescale 1ns/10ps
module wdcm_clkmon (
   input  wire logic clk_sys_i,
   input  wire logic rst_b_i,
   input  wire logic enable_i,
   input  wire logic bus_tick_i,
   output logic      cm_fire_o,
   output logic      cm_drive_o
);
   import wdcm_pkg::*;

   wdcm_cm_type state;
   wdcm_cm_type next_state;
   logic [9:0]  gap;
   logic [9:0]  next_gap;
   logic [2:0]  tail;
   logic [2:0]  next_tail;
   logic        next_fire;

   // ==========================================================
   // detection
   always_comb begin
      next_state = state;
      next_tail  = tail;
      next_fire  = 1'b0;
      if (bus_tick_i) begin
         next_gap = 10'h000;
      end else if (gap != CM_WINDOW_CYC) begin
         next_gap = gap + 10'h001;
      end else begin
         next_gap = gap;
      end
      unique case (state)
         CM_IDLE: begin
            // gap saturates, so a stopped oscillator is caught too
            if (enable_i && gap == CM_WINDOW_CYC && !bus_tick_i) begin
               next_state = CM_ABSENT;
               next_fire  = 1'b1;
            end
         end
         CM_ABSENT: begin
            // absent clock: drive until ticks come back
            if (bus_tick_i) begin
               next_state = CM_TAIL;
               next_tail  = CM_TAIL_BUS;
            end
         end
         CM_TAIL: begin
            // a slow clock still gets four full bus cycles of reset
            if (bus_tick_i) begin
               next_tail = tail - 3'h1;
               if (tail == 3'h1) begin
                  next_state = CM_IDLE;
               end
            end
         end
         default: next_state = CM_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         state     <= CM_IDLE;
         gap       <= 10'h000;
         tail      <= 3'h0;
         cm_fire_o <= 1'b0;
      end else begin
         state     <= next_state;
         gap       <= next_gap;
         tail      <= next_tail;
         cm_fire_o <= next_fire;
      end
   end

   assign cm_drive_o = (state != CM_IDLE);

endmodule

// file: testbench/wdcm_assertions.sv
/*
 * port checker of the watchdog and clock monitor top.
 * assumes one clock domain and the synchronous active-low reset.
 */
`timescale 1ns/10ps
module wdcm_assertions #(
   parameter int unsigned WDOG_TIMEOUT = wdcm_pkg::WDOG_TIMEOUT_BUS
) (
   input wire logic        clk_sys_i,
   input wire logic        rst_b_i,
   input wire logic        s_axi_rvalid_o,
   input wire logic        s_axi_rready_i,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic        wait_mode_i,
   input wire logic        irq_any_i,
   input wire logic        ext_irq_b_i,
   input wire logic        reset_pin_oe_b_o,
   input wire logic        osc_run_o,
   input wire logic        bus_tick_o,
   input wire logic        sys_reset_o,
   input wire logic        irq_mask_clear_o,
   input wire logic        wait_exit_o
);
   // ==========================================================
   // properties
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);

   tick_gap_a: assert property (bus_tick_o |=> !bus_tick_o [*8])
      else $error("bus ticks too close");
   stop_quiet_a: assert property (!osc_run_o |-> !bus_tick_o)
      else $error("tick while stopped");
   mask_clear_a: assert property (irq_mask_clear_o |-> !osc_run_o && $past(osc_run_o))
      else $error("mask clear outside stop entry");
   wait_exit_a: assert property (wait_exit_o == (wait_mode_i && (irq_any_i || sys_reset_o)))
      else $error("wait exit wrong");
   reset_len_a: assert property ($rose(sys_reset_o) |-> sys_reset_o [*8])
      else $error("system reset too short");
   pin_cause_a: assert property (!reset_pin_oe_b_o |-> ##[0:2] sys_reset_o)
      else $error("pin driven without reset");
   // the interrupt input must be idle for the synchroniser depth
   stop_hold_a: assert property (!osc_run_o && !sys_reset_o && ext_irq_b_i && $past(ext_irq_b_i)
      && $past(ext_irq_b_i, 2) |=> !osc_run_o || sys_reset_o)
      else $error("stop left without cause");
   read_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
      s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("read data not held");
endmodule

bind wdcm_top wdcm_assertions #(.WDOG_TIMEOUT(WDOG_TIMEOUT)) u_chk (.clk_sys_i, .rst_b_i,
   .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o, .wait_mode_i, .irq_any_i, .ext_irq_b_i,
   .reset_pin_oe_b_o, .osc_run_o, .bus_tick_o, .sys_reset_o, .irq_mask_clear_o, .wait_exit_o);

// file: testbench/wdcm_top_bench.sv
/*
 * self-checking bench of the watchdog and clock monitor top.
 * assumes the package constants and a short watchdog timeout parameter.
 */
`timescale 1ns/10ps
module wdcm_top_bench;
   import wdcm_pkg::*;
   // ==========================================================
   // signals
   localparam int unsigned WT = 64;
   logic        clk = 1'h0, rst_b = 1'h0;
   logic [15:0] awa = 16'h0, ara = 16'h0;
   logic [31:0] wd = 32'h0, rdt, seed = 32'he5f03e8b;
   logic        awv = 1'h0, wv = 1'h0, arv = 1'h0, rry = 1'h0;
   logic [7:0]  pbo = 8'h0;
   logic        stp = 1'h0, wtm = 1'h0, irq = 1'h0, flt = 1'h0, irq_b = 1'h1;
   logic        awr, wrd, bv, arr, rv, pin, oe, osc, tick, srst, mclr, wex;
   logic [1:0]  brs, rrs;
   int          failures = 0, total_checks = 0;

   // reset pin has a pull-up: it reads back low only while the device drives it
   wdcm_top #(.WDOG_TIMEOUT(WT)) dut (.clk_sys_i(clk), .rst_b_i(rst_b),
      .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
      .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd),
      .s_axi_bresp_o(brs), .s_axi_bvalid_o(bv), .s_axi_bready_i(1'h1),
      .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
      .s_axi_rdata_o(rdt), .s_axi_rresp_o(rrs), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
      .port_b_option_i(pbo), .stop_enter_i(stp), .wait_mode_i(wtm), .irq_any_i(irq),
      .clock_fault_i(flt), .ext_irq_b_i(irq_b), .reset_pin_i(oe | pin), .reset_pin_o(pin),
      .reset_pin_oe_b_o(oe), .osc_run_o(osc), .bus_tick_o(tick), .sys_reset_o(srst),
      .irq_mask_clear_o(mclr), .wait_exit_o(wex));

   initial begin
      forever #12.5 clk = ~clk;
   end

   // ==========================================================
   // helpers
   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function logic near(input logic [31:0] g, input int e, input int t);
      return (int'(g) >= e - t) && (int'(g) <= e + t);
   endfunction

   task report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task ok(input logic c);
      chk({31'h0, c}, 32'h1);
   endtask

   task hang(input int n);
      if (n > 2000) begin
         failures++;
         $display("mismatch at %0t: wait limit used up", $time);
         report_and_stop;
      end
   endtask

   // both channels offered together, each released once taken
   task wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ta, tw, tb;
      int   n;
      awa <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      tb = 1'h0;
      n = 0;
      while (!tb) begin
         @(negedge clk);
         ta = awv & awr;
         tw = wv & wrd;
         tb = bv;
         r = brs;
         n++;
         @(posedge clk);
         if (ta) awv <= 1'h0;
         if (tw) wv <= 1'h0;
         hang(n);
      end
   endtask

   // ready raised late on purpose so the slave has to hold its answer
   task rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ta, tv;
      int   n;
      ara <= a;
      arv <= 1'h1;
      tv = 1'h0;
      n = 0;
      while (!tv) begin
         @(negedge clk);
         ta = arv & arr;
         tv = rv & rry;
         d = rdt;
         r = rrs;
         n++;
         @(posedge clk);
         if (ta) arv <= 1'h0;
         rry <= rv & !tv;
         hang(n);
      end
   endtask

   task wait_for(input int sel);
      logic hit;
      int   n;
      hit = 1'h0;
      n = 0;
      while (!hit) begin
         @(negedge clk);
         hit = (sel == 0) ? (srst === 1'h1) : (sel == 1) ? (srst === 1'h0) : (oe === 1'h1);
         n++;
         hang(n);
      end
      @(posedge clk);
   endtask

   // ==========================================================
   // scenarios
   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      time         t0;
      repeat (20) @(posedge clk);
      rst_b <= 1'h1;
      @(posedge clk);
      rd(ADDR_OPTION, d, r);
      chk(d, 32'h0);
      for (int i = 0; i < 4; i++) begin
         pbo <= 8'(xs());
         @(posedge clk);
         rd(ADDR_SERVICE, d, r);
         chk(d, {24'h0, pbo});
      end
      rd(16'h0100, d, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      wr(16'h0100, 32'h1, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      $display("test registers done");
      wtm <= 1'h1;
      wr(ADDR_OPTION, 32'h3, r);
      wr(ADDR_SERVICE, 32'h0, r);
      repeat (400) @(posedge clk);
      rd(ADDR_COUNT, d, r);
      ok(near(d, 20, 2));
      irq <= 1'h1;
      @(negedge clk);
      chk({31'h0, wex}, 32'h1);
      @(posedge clk);
      irq <= 1'h0;
      wr(ADDR_SERVICE, xs() | 32'h1, r);
      rd(ADDR_COUNT, d, r);
      ok(d >= 32'h14);
      wr(ADDR_SERVICE, xs() & 32'hfffffffe, r);
      t0 = $time;
      rd(ADDR_COUNT, d, r);
      ok(d <= 32'h3);
      wait_for(0);
      ok(near(32'(($time - t0) / 25), 1270, 14));
      chk({31'h0, wex}, 32'h1);
      wtm <= 1'h0;
      rd(ADDR_CONTROL, d, r);
      chk({31'h0, d[7]}, 32'h1);
      rd(ADDR_CONTROL, d, r);
      chk({31'h0, d[7]}, 32'h0);
      wait_for(1);
      rd(ADDR_COUNT, d, r);
      ok(d <= 32'h3);
      $display("test watchdog done");
      wr(ADDR_OPTION, 32'h0, r);
      wr(ADDR_CONTROL, 32'h10, r);
      wr(ADDR_CONTROL, 32'h0, r);
      rd(ADDR_CONTROL, d, r);
      chk(d, 32'h10);
      flt <= 1'h1;
      t0 = $time;
      wait_for(0);
      ok(near(32'(($time - t0) / 25), 792, 12));
      repeat (100) @(posedge clk);
      chk({30'h0, srst, oe}, 32'h2);
      flt <= 1'h0;
      t0 = $time;
      wait_for(2);
      ok(near(32'(($time - t0) / 25), 83, 23));
      rd(ADDR_CONTROL, d, r);
      chk(d, 32'h90);
      $display("test monitor done");
      wr(ADDR_OPTION, 32'h7, r);
      repeat (60) @(posedge clk);
      stp <= 1'h1;
      @(posedge clk);
      stp <= 1'h0;
      @(negedge clk);
      chk({30'h0, osc, mclr}, 32'h1);
      @(posedge clk);
      rd(ADDR_COUNT, d, r);
      chk(d, 32'h0);
      repeat (400) @(posedge clk);
      rd(ADDR_COUNT, d, r);
      chk({d[30:0], srst}, 32'h0);
      wait_for(0);
      chk({31'h0, oe}, 32'h1);
      $display("test stop done");
      // second reset in mid-run, then a stop left through the interrupt pin
      rst_b <= 1'h0;
      repeat (2) @(posedge clk);
      rst_b <= 1'h1;
      @(posedge clk);
      wr(ADDR_CONTROL, 32'h0, r);
      wr(ADDR_CONTROL, 32'h10, r);
      rd(ADDR_CONTROL, d, r);
      chk(d, 32'h0);
      stp <= 1'h1;
      @(posedge clk);
      stp <= 1'h0;
      repeat (20) @(posedge clk);
      irq_b <= 1'h0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      ok(!osc);
      @(negedge clk);
      ok(osc);
      chk({31'h0, srst}, 32'h0);
      @(posedge clk);
      irq_b <= 1'h1;
      $display("test interrupt exit done");
      report_and_stop;
   end
endmodule
